// *** core/spsyn_core.sv ***
// Digital core of a serially programmed PLL synthesiser
// Summary of operation
// - Eleven-bit reference divider derives the comparison frequency from oscillator clock.
// - Ten-bit main counter and seven-bit swallow counter form loop ratio.
// - Two band outputs held in latches, updated from serial band data.
// - A thirty-bit load programs reference, main, swallow and band settings.
// - A nineteen-bit load updates swallow, main and band, keeping reference.
// - Counter outputs and modulus control change on the rising clock edge.
// - Modulus control output steers an external two-modulus prescaler.
// - Coarse output pulses up when VCO leads, down when reference leads, outside fine window; else off.
// - Open-drain lock output pulled low while phase error is inside window.
// - Divided VCO signal also presented on an open-drain output.
`timescale 1ns/1ps
`include "spsyn_defs.svh"
module spsyn_core
  import spsyn_pkg::*;
#(
  parameter int REF_W = `SPSYN_REF_W,
  parameter int MAIN_W = `SPSYN_MAIN_W,
  parameter int SWAL_W = `SPSYN_SWAL_W,
  parameter int WIN_W = `SPSYN_WIN_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Serial programming pins
  input wire spsyn_serial_s serial_i,
  // Prescaled VCO pin, sampled
  input wire logic prescaled_vco_input_i,
  // Fine window width in oscillator cycles
  input wire logic [WIN_W-1:0] lock_window_i,
  // Prescaler and band outputs
  output logic modulus_control_o,
  output logic [`SPSYN_BAND_W-1:0] band_o,
  // Reference divided output (observable)
  output logic divided_reference_o,
  // Open-drain divided VCO: out and enable_n
  output logic divided_vco_out_o,
  output logic divided_vco_out_oe_n_o,
  // Open-drain lock indication
  output logic lock_indicate_o,
  output logic lock_indicate_oe_n_o,
  // Three-state coarse phase error
  output logic coarse_phase_error_out_o,
  output logic coarse_phase_error_out_oe_n_o
);
  localparam int SR_W = `SPSYN_FULL_BITS;

  // Synchronisers for pins
  logic [1:0] sclk_sync_reg, sdat_sync_reg, sen_sync_reg, fin_sync_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sclk_sync_reg <= 2'b11;
      sdat_sync_reg <= 2'b00;
      sen_sync_reg <= 2'b00;
      fin_sync_reg <= 2'b00;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], serial_i.clk};
      sdat_sync_reg <= {sdat_sync_reg[0], serial_i.data};
      sen_sync_reg <= {sen_sync_reg[0], serial_i.enable};
      fin_sync_reg <= {fin_sync_reg[0], prescaled_vco_input_i};
    end
  end

  // Edge detection on synchronised levels
  logic sclk_d_reg, sen_d_reg, fin_d_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sclk_d_reg <= 1'b1;
      sen_d_reg <= 1'b0;
      fin_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_sync_reg[1];
      sen_d_reg <= sen_sync_reg[1];
      fin_d_reg <= fin_sync_reg[1];
    end
  end
  logic sclk_fall, sen_fall, fin_rise;
  assign sclk_fall = sclk_d_reg & ~sclk_sync_reg[1];
  assign sen_fall = sen_d_reg & ~sen_sync_reg[1];
  assign fin_rise = fin_sync_reg[1] & ~fin_d_reg;

  // Serial shift register and bit count while enabled
  logic [SR_W-1:0] shift_reg;
  logic [`SPSYN_CNT_W-1:0] bits_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shift_reg <= '0;
      bits_reg <= '0;
    end else if (sen_fall) begin
      bits_reg <= '0;
    end else if (sen_sync_reg[1] && sclk_fall) begin
      shift_reg <= {shift_reg[SR_W-2:0], sdat_sync_reg[1]};
      if (bits_reg != 5'h1f) begin
        bits_reg <= bits_reg + 5'h01;
      end
    end
  end

  // Latch transfer on enable fall; short load keeps the reference
  logic [REF_W-1:0] ref_lat_reg;
  logic [MAIN_W-1:0] main_lat_reg;
  logic [SWAL_W-1:0] swal_lat_reg;
  logic [`SPSYN_BAND_W-1:0] band_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ref_lat_reg <= `SPSYN_REF_RST;
      main_lat_reg <= `SPSYN_MAIN_RST;
      swal_lat_reg <= `SPSYN_SWAL_RST;
      band_reg <= '0;
    end else if (sen_fall) begin
      if (bits_reg >= 5'(`SPSYN_FULL_BITS)) begin
        // Order on the wire: swallow, main, band, reference
        swal_lat_reg <= shift_reg[29:23];
        main_lat_reg <= shift_reg[22:13];
        band_reg <= shift_reg[12:11];
        ref_lat_reg <= shift_reg[10:0];
      end else if (bits_reg >= 5'(`SPSYN_SHORT_BITS)) begin
        swal_lat_reg <= shift_reg[18:12];
        main_lat_reg <= shift_reg[11:2];
        band_reg <= shift_reg[1:0];
      end
    end
  end

  // Swallow value that an enable fall is about to latch
  logic [SWAL_W-1:0] swal_load;
  always_comb begin
    swal_load = swal_lat_reg;
    if (bits_reg >= 5'(`SPSYN_FULL_BITS)) begin
      swal_load = shift_reg[29:23];
    end else if (bits_reg >= 5'(`SPSYN_SHORT_BITS)) begin
      swal_load = shift_reg[18:12];
    end
  end

  // Reference divider: toggles every ref_lat_reg oscillator cycles
  logic [REF_W-1:0] ref_cnt_reg;
  logic fr_reg, fr_d_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ref_cnt_reg <= '0;
      fr_reg <= 1'b0;
    end else if (sen_fall) begin
      ref_cnt_reg <= '0; // Resynchronise both detector inputs
      fr_reg <= 1'b0;
    end else if (ref_cnt_reg + 11'h001 >= ref_lat_reg) begin
      ref_cnt_reg <= '0;
      fr_reg <= ~fr_reg;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 11'h001;
    end
  end

  // Swallow and main counters clocked by prescaler output edges
  logic [MAIN_W-1:0] main_cnt_reg;
  logic [SWAL_W-1:0] swal_cnt_reg;
  logic mc_reg, fv_pulse_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      main_cnt_reg <= '0;
      swal_cnt_reg <= '0;
      mc_reg <= 1'b0;
      fv_pulse_reg <= 1'b0;
    end else if (sen_fall) begin
      main_cnt_reg <= '0;
      swal_cnt_reg <= '0;
      mc_reg <= (swal_load == '0); // first cycle uses the new swallow value
      fv_pulse_reg <= 1'b0;
    end else if (fin_rise) begin
      if (main_cnt_reg + 10'h001 >= main_lat_reg) begin
        main_cnt_reg <= '0;
        swal_cnt_reg <= '0;
        mc_reg <= (swal_lat_reg == '0);
        fv_pulse_reg <= 1'b1;
      end else begin
        main_cnt_reg <= main_cnt_reg + 10'h001;
        fv_pulse_reg <= 1'b0;
        if (!mc_reg) begin
          swal_cnt_reg <= swal_cnt_reg + 7'h01;
          if (swal_cnt_reg + 7'h01 >= swal_lat_reg) begin
            mc_reg <= 1'b1;
          end
        end
      end
    end else begin
      fv_pulse_reg <= 1'b0;
    end
  end

  // Phase/frequency detector on rising edges of both divided signals
  logic fr_rise;
  assign fr_rise = fr_reg & ~fr_d_reg;
  spsyn_pd_e pd_reg;
  logic [WIN_W-1:0] err_cnt_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fr_d_reg <= 1'b0;
      pd_reg <= SPSYN_PD_IDLE;
      err_cnt_reg <= '0;
    end else if (sen_fall) begin
      fr_d_reg <= fr_reg;
      pd_reg <= SPSYN_PD_IDLE; // Detector restarts with both dividers
      err_cnt_reg <= '0;
    end else begin
      fr_d_reg <= fr_reg;
      case (pd_reg)
        SPSYN_PD_IDLE: begin
          err_cnt_reg <= '0;
          if (fv_pulse_reg && !fr_rise) begin
            pd_reg <= SPSYN_PD_UP;
          end else if (fr_rise && !fv_pulse_reg) begin
            pd_reg <= SPSYN_PD_DOWN;
          end
        end
        SPSYN_PD_UP: begin
          if (fr_rise) begin
            pd_reg <= SPSYN_PD_IDLE;
          end else if (err_cnt_reg != '1) begin
            err_cnt_reg <= err_cnt_reg + 1'b1;
          end
        end
        SPSYN_PD_DOWN: begin
          if (fv_pulse_reg) begin
            pd_reg <= SPSYN_PD_IDLE;
          end else if (err_cnt_reg != '1) begin
            err_cnt_reg <= err_cnt_reg + 1'b1;
          end
        end
        default: pd_reg <= SPSYN_PD_IDLE;
      endcase
    end
  end

  // Output registers: coarse drive only outside fine window
  logic in_window;
  assign in_window = (err_cnt_reg < lock_window_i);
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      modulus_control_o <= 1'b0;
      band_o <= '0;
      divided_reference_o <= 1'b0;
      divided_vco_out_o <= 1'b0;
      divided_vco_out_oe_n_o <= 1'b1;
      lock_indicate_o <= 1'b0;
      lock_indicate_oe_n_o <= 1'b1;
      coarse_phase_error_out_o <= 1'b0;
      coarse_phase_error_out_oe_n_o <= 1'b1;
    end else begin
      modulus_control_o <= mc_reg;
      band_o <= band_reg;
      divided_reference_o <= fr_reg;
      divided_vco_out_o <= 1'b0;
      divided_vco_out_oe_n_o <= ~fv_pulse_reg;
      lock_indicate_o <= 1'b0;
      lock_indicate_oe_n_o <= ~in_window;
      coarse_phase_error_out_o <= (pd_reg == SPSYN_PD_UP);
      coarse_phase_error_out_oe_n_o <= (pd_reg == SPSYN_PD_IDLE) || in_window;
    end
  end
endmodule

// *** include/spsyn_defs.svh ***
// Constants for the serially programmed synthesiser core
`ifndef SPSYN_DEFS_SVH
`define SPSYN_DEFS_SVH
`define SPSYN_REF_W 11
`define SPSYN_MAIN_W 10
`define SPSYN_SWAL_W 7
`define SPSYN_BAND_W 2
`define SPSYN_FULL_BITS 30
`define SPSYN_SHORT_BITS 19
`define SPSYN_CNT_W 5
`define SPSYN_REF_RST 11'h0190
`define SPSYN_MAIN_RST 10'h0157
`define SPSYN_SWAL_RST 7'h30
`define SPSYN_WIN_W 4
`define SPSYN_WIN_RST 4'h2
`endif

// *** include/spsyn_pkg.sv ***
// Types for the serially programmed synthesiser core
package spsyn_pkg;
  // Serial port pins grouped
  typedef struct packed {
    logic clk;
    logic data;
    logic enable;
  } spsyn_serial_s;
  // Phase detector state
  typedef enum logic [1:0] {
    SPSYN_PD_IDLE = 2'b00,
    SPSYN_PD_UP = 2'b01,
    SPSYN_PD_DOWN = 2'b10
  } spsyn_pd_e;
endpackage

// *** dv/spsyn_core_monitor.sv ***
// Port checker for the synthesiser core
`timescale 1ns/1ps
module spsyn_core_monitor
  import spsyn_pkg::*;
#(parameter int WIN_W = 4) (
  // Core inputs
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire spsyn_serial_s serial_i,
  input wire logic prescaled_vco_input_i,
  input wire logic [WIN_W-1:0] lock_window_i,
  // Core outputs
  input wire logic modulus_control_o,
  input wire logic [1:0] band_o,
  input wire logic divided_vco_out_o,
  input wire logic divided_vco_out_oe_n_o,
  input wire logic lock_indicate_o,
  input wire logic lock_indicate_oe_n_o,
  input wire logic coarse_phase_error_out_oe_n_o
);
  logic pv_reg, en_reg;
  logic [3:0] quiet_reg;
  // Cycles since prescaled input or enable moved
  always_ff @(posedge clock_i) begin
    pv_reg <= prescaled_vco_input_i;
    en_reg <= serial_i.enable;
    if (pv_reg != prescaled_vco_input_i || en_reg != serial_i.enable) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_drain_low: assert property (!divided_vco_out_o && !lock_indicate_o)
    else $error("open-drain data high");
  chk_vco_gap: assert property (
    !divided_vco_out_oe_n_o |=> divided_vco_out_oe_n_o [*3]) else $error("vco pulses close");
  chk_lock_quiet: assert property (
    !lock_indicate_oe_n_o |-> coarse_phase_error_out_oe_n_o) else $error("coarse on in lock");
  chk_band_hold: assert property (
    $changed(band_o) |-> !serial_i.enable && !$past(serial_i.enable, 4))
    else $error("band moved mid load");
  chk_window_zero: assert property (
    $past(lock_window_i) == 0 && $past(lock_window_i, 2) == 0 |-> lock_indicate_oe_n_o)
    else $error("lock with empty window");
  chk_mc_cause: assert property (
    $changed(modulus_control_o) |-> quiet_reg < 4'h8) else $error("modulus moved idle");
  chk_vco_cause: assert property (
    !divided_vco_out_oe_n_o |-> quiet_reg < 4'h8) else $error("vco pulse idle");
  chk_reset_idle: assert property (
    $rose(rst_n_i) |-> divided_vco_out_oe_n_o && lock_indicate_oe_n_o
      && coarse_phase_error_out_oe_n_o && !modulus_control_o && band_o == 2'b00)
    else $error("outputs busy after reset");
endmodule
bind spsyn_core spsyn_core_monitor #(.WIN_W(WIN_W)) i_mon (.*);

// *** dv/spsyn_host.sv ***
// Processor model that loads the serial port
`timescale 1ns/1ps
module spsyn_host
  import spsyn_pkg::*;
(
  // Clock and load request
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic [4:0] nbits_i,
  input wire logic [30:0] word_i,
  // Serial pins and status
  output spsyn_serial_s serial_o,
  output logic busy_o
);
  // One frame per request, MSB first, clock idles high
  initial begin
    serial_o = '{clk: 1'b1, data: 1'b1, enable: 1'b0};
    busy_o = 1'b0;
    forever begin
      @(posedge clock_i);
      if (go_i) begin
        @(negedge clock_i);
        busy_o = 1'b1;
        serial_o.enable = 1'b1;
        repeat (4) @(negedge clock_i);
        for (int i = int'(nbits_i) - 1; i >= 0; i--) begin
          serial_o.clk = 1'b0;
          serial_o.data = word_i[i];
          repeat (slow_i ? 6 : 3) @(negedge clock_i);
          serial_o.clk = 1'b1;
          repeat (slow_i ? 6 : 3) @(negedge clock_i);
        end
        serial_o.enable = 1'b0;
        serial_o.data = 1'b1; // Pull-up level once released
        repeat (8) @(negedge clock_i);
        busy_o = 1'b0;
      end
    end
  end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the synthesiser core
`timescale 1ns/1ps
module tb;
  import spsyn_pkg::*;
  logic clock_i = 1'b0, rst_n_i = 1'b0, pv = 1'b0, pq, rp, pv_run = 1'b1, go = 1'b0;
  logic slow = 1'b0, busy, mc, dref, vco_oe_n, pd_up, pd_oe_n;
  int up_n = 0, dn_n = 0;
  logic [4:0] nbits = '0;
  logic [30:0] word = '0;
  logic [3:0] win = '0;
  logic [1:0] band;
  spsyn_serial_s ser;
  int err_count = 0, compares = 0, cyc = 0, rc = 0, rhalf = 0, rn = 0;
  int ec = 0, vm = 0, pc = 0, mh = 0, mhi = 0, ea = 48, em = 343, er = 400, eb = 0;
  int nq[$] = '{30, 19, 24, 10, 31, 19};
  bit [31:0] seed = 32'h4be1_b7d2;
  always #10 clock_i = ~clock_i;
  spsyn_core i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .serial_i(ser),
    .prescaled_vco_input_i(pv), .lock_window_i(win), .modulus_control_o(mc),
    .band_o(band), .divided_reference_o(dref), .divided_vco_out_o(),
    .divided_vco_out_oe_n_o(vco_oe_n), .lock_indicate_o(), .lock_indicate_oe_n_o(),
    .coarse_phase_error_out_o(pd_up), .coarse_phase_error_out_oe_n_o(pd_oe_n));
  spsyn_host i_host (.clock_i(clock_i), .go_i(go), .slow_i(slow), .nbits_i(nbits),
    .word_i(word), .serial_o(ser), .busy_o(busy));
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_cnt(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_band(logic [1:0] got, logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Prescaled input with period of eight clocks, and run limit
  always @(negedge clock_i) begin
    cyc <= cyc + 1;
    if (pv_run && cyc % 4 == 0) pv <= ~pv;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // Spans between output events
  always @(posedge clock_i) begin
    pq <= pv;
    rp <= dref;
    // Driven cycles of the coarse output, by direction
    if (pd_oe_n === 1'b0 && pd_up === 1'b1) up_n <= up_n + 1;
    if (pd_oe_n === 1'b0 && pd_up === 1'b0) dn_n <= dn_n + 1;
    rc <= (dref !== rp) ? 1 : rc + 1;
    if (dref !== rp) begin
      rhalf <= rc;
      rn <= rn + 1;
    end
    if (vco_oe_n === 1'b0) begin
      vm <= ec;
      mhi <= mh;
      ec <= int'(pv && !pq);
      mh <= 0;
      pc <= pc + 1;
    end else begin
      ec <= ec + int'(pv && !pq);
      mh <= mh + int'(mc && pv && !pq);
    end
  end
  // Let three divided VCO pulses and three reference toggles pass, then compare with the model
  task automatic settle_check();
    int p0 = pc;
    int r0 = rn;
    int u0 = up_n;
    int d0 = dn_n;
    for (int k = 0; k < 30000 && (pc < p0 + 3 || rn < r0 + 3); k++) @(negedge clock_i);
    chk_band(band, eb[1:0]);
    chk_cnt(rhalf, er);
    chk_cnt(vm, em);
    chk_cnt(mhi, em - ea);
    // Clearly faster reference: only down drive; clearly faster VCO: only up
    if (8 * em > 4 * er + 16) begin
      chk_cnt(up_n - u0, 0);
      if (win == 4'h0) chk_cnt(int'(dn_n > d0), 1);
    end else if (2 * er > 16 * em + 32) begin
      chk_cnt(dn_n - d0, 0);
      if (win == 4'h0) chk_cnt(int'(up_n > u0), 1);
    end
    $display("test done at %0t", $time);
  endtask
  // Loads of every length class, random settings
  initial begin
    int a, m, b, r;
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    settle_check();
    foreach (nq[i]) begin
      a = rnd() % 8;
      m = 8 + rnd() % 8;
      b = rnd() % 4;
      r = (i == 4) ? 150 + rnd() % 100 : 3 + rnd() % 61;
      win = i[0] ? 4'(rnd()) : 4'h0;
      nbits = 5'(nq[i]);
      word = nq[i] >= 30 ? {1'b1, 7'(a), 10'(m), 2'(b), 11'(r)}
        : {12'(rnd()), 7'(a), 10'(m), 2'(b)};
      if (nq[i] >= 19) begin
        ea = a;
        em = m;
        eb = b;
      end
      if (nq[i] >= 30) er = r;
      slow = i[0];
      go = 1'b1;
      @(negedge clock_i);
      go = 1'b0;
      repeat (2) @(negedge clock_i);
      for (int k = 0; k < 2000 && busy; k++) @(negedge clock_i);
      settle_check();
    end
    pv_run = 1'b0;
    repeat (200) @(negedge clock_i);
    tally_and_finish();
  end
endmodule
